// ==== rtl/esq_host.sv ====
// Core-side sequencer: APB command registers driving EEPROM I/O accesses
`include "esq_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module esq_host
  import esq_pkg::*;
#(
  parameter int unsigned AW = 9
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  esq_io_if.core io
);
  if (AW < 7 || AW > 9) begin : g_bad_aw
    $error("AW must be 7 to 9");
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  esq_hstate_t state_ff;
  esq_hop_t op_ff;
  logic [AW-1:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] result_ff;
  logic done_ff;
  logic [2:0] step_ff;
  logic [31:0] prdata_ff;

  wire idle = (state_ff == H_IDLE);
  wire sel_cmd = (paddr == `ESQ_APB_CMD);
  wire sel_addr = (paddr == `ESQ_APB_ADDR);
  wire sel_wdata = (paddr == `ESQ_APB_WDATA);
  wire sel_stat = (paddr == `ESQ_APB_STATUS);
  wire mapped = sel_cmd || sel_addr || sel_wdata || sel_stat;
  wire apb_wr = psel && penable && pwrite && mapped;
  wire go = apb_wr && sel_cmd && pwdata[`ESQ_CMD_GO] && idle;
  wire [31:0] stat_rd = {16'h0000, result_ff, 6'h00, done_ff, !idle};
  wire [31:0] rd_mux = sel_cmd ? {30'h0, op_ff}
                     : sel_addr ? 32'(addr_ff)
                     : sel_wdata ? {24'h0, wdata_ff}
                     : sel_stat ? stat_rd : 32'h0;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_ff;

  // ----------------------------------------------------------------------
  // I/O access per step
  // ----------------------------------------------------------------------
  wire [15:0] addr16 = 16'(addr_ff);
  wire [7:0] mode8 = {6'h00, op_ff} << `ESQ_CTRL_MODE_LO;
  wire [7:0] arm8 = mode8 | (8'h01 << `ESQ_CTRL_ARM);
  logic [5:0] s_addr;
  logic [7:0] s_wdata;
  logic s_rd;
  logic s_last;

  always_comb begin
    s_rd = 1'b0;
    s_last = 1'b0;
    s_wdata = 8'h00;
    s_addr = `ESQ_IO_CTRL;
    if (op_ff == OP_READ) begin
      case (step_ff)
        3'h0: begin
          s_addr = `ESQ_IO_ADRL;
          s_wdata = addr16[7:0];
        end
        3'h1: begin
          s_addr = `ESQ_IO_ADRH;
          s_wdata = addr16[15:8];
        end
        3'h2: s_wdata = 8'h01 << `ESQ_CTRL_READ;
        default: begin
          s_addr = `ESQ_IO_DATA;
          s_rd = 1'b1;
          s_last = 1'b1;
        end
      endcase
    end else begin
      case (step_ff)
        3'h0: s_wdata = mode8;
        3'h1: begin
          s_addr = `ESQ_IO_ADRL;
          s_wdata = addr16[7:0];
        end
        3'h2: begin
          s_addr = `ESQ_IO_ADRH;
          s_wdata = addr16[15:8];
        end
        3'h3: begin
          s_addr = `ESQ_IO_DATA;
          s_wdata = wdata_ff;
        end
        3'h4: s_wdata = arm8;
        default: begin
          // Strobe directly follows arm, well inside the window
          s_wdata = arm8 | (8'h01 << `ESQ_CTRL_STROBE);
          s_last = 1'b1;
        end
      endcase
    end
  end

  wire poll_go = (state_ff == H_POLL) && !io.stall;
  wire step_go = (state_ff == H_STEP) && !io.stall;
  assign io.addr = poll_go ? `ESQ_IO_CTRL : s_addr;
  assign io.wdata = s_wdata;
  assign io.wr = step_go && !s_rd;
  assign io.rd = poll_go || (step_go && s_rd);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  logic [2:0] nxt_state;
  always_comb begin
    case (state_ff)
      H_IDLE: nxt_state = go ? H_POLL : H_IDLE;
      H_POLL: nxt_state = poll_go ? H_CHK : H_POLL;
      // Wait out a running programming cycle before touching registers
      H_CHK: nxt_state = io.rdata[`ESQ_CTRL_STROBE] ? H_POLL : H_STEP;
      H_STEP: nxt_state = !(step_go && s_last) ? H_STEP
                        : s_rd ? H_FETCH : H_IDLE;
      H_FETCH: nxt_state = H_IDLE;
      default: nxt_state = H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= H_IDLE;
      step_ff <= 3'h0;
    end else begin
      state_ff <= esq_hstate_t'(nxt_state);
      step_ff <= (state_ff == H_CHK) ? 3'h0 : step_go ? step_ff + 3'h1 : step_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_ff <= OP_ATOMIC;
      addr_ff <= '0;
      wdata_ff <= 8'h00;
      result_ff <= 8'h00;
      done_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      prdata_ff <= (psel && !penable) ? rd_mux : prdata_ff;
      op_ff <= go ? esq_hop_t'(pwdata[1:0]) : op_ff;
      addr_ff <= (apb_wr && sel_addr && idle) ? AW'(pwdata) : addr_ff;
      wdata_ff <= (apb_wr && sel_wdata && idle) ? pwdata[7:0] : wdata_ff;
      result_ff <= (state_ff == H_FETCH) ? io.rdata : result_ff;
      done_ff <= go ? 1'b0 : ((step_go && s_last && !s_rd) ||
                              (state_ff == H_FETCH)) ? 1'b1 : done_ff;
    end
  end
endmodule : esq_host

`default_nettype wire

// ==== rtl/esq_regs.svh ====
// Constants for the EEPROM byte access sequencer: offsets, fields, timing
`ifndef ESQ_REGS_SVH
`define ESQ_REGS_SVH

// ----------------------------------------------------------------------
// I/O space locations of the device registers
// ----------------------------------------------------------------------
`define ESQ_IO_CTRL 6'h1c
`define ESQ_IO_DATA 6'h1d
`define ESQ_IO_ADRL 6'h1e
`define ESQ_IO_ADRH 6'h1f

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define ESQ_CTRL_READ 0
`define ESQ_CTRL_STROBE 1
`define ESQ_CTRL_ARM 2
`define ESQ_CTRL_MODE_LO 4
`define ESQ_CTRL_MODE_HI 5

// ----------------------------------------------------------------------
// Reset values and memory contents
// ----------------------------------------------------------------------
`define ESQ_MODE_RST 2'h0
`define ESQ_ERASED 8'hff
`define ESQ_BYTES 512

// ----------------------------------------------------------------------
// Timing: core stalls and arm window in pclk cycles
// ----------------------------------------------------------------------
`define ESQ_STALL_READ 3'h4
`define ESQ_STALL_PROG 3'h2
`define ESQ_ARM_WINDOW 3'h4

// ----------------------------------------------------------------------
// Timing: programming times, counted in oscillator ticks
// ----------------------------------------------------------------------
`define ESQ_OSC_TICK_NS 1000
`define ESQ_T_ATOMIC_US 3400
`define ESQ_T_SPLIT_US 1800
`define ESQ_ATOMIC_TICKS ((`ESQ_T_ATOMIC_US * 1000) / `ESQ_OSC_TICK_NS)
`define ESQ_SPLIT_TICKS ((`ESQ_T_SPLIT_US * 1000) / `ESQ_OSC_TICK_NS)

// ----------------------------------------------------------------------
// APB register offsets of the host controller
// ----------------------------------------------------------------------
`define ESQ_APB_CMD 8'h00
`define ESQ_APB_ADDR 8'h04
`define ESQ_APB_WDATA 8'h08
`define ESQ_APB_STATUS 8'h0c
`define ESQ_CMD_GO 8

`endif

// ==== rtl/esq_pkg.sv ====
// Types for both ends of the EEPROM byte access sequencer: device modes, host ops and host states
package esq_pkg;

  typedef enum logic [1:0] {
    PM_ATOMIC = 2'b00,
    PM_ERASE = 2'b01,
    PM_WRITE = 2'b10,
    PM_RSVD = 2'b11
  } esq_pmode_t;

  typedef enum logic [1:0] {
    OP_ATOMIC = 2'b00,
    OP_ERASE = 2'b01,
    OP_WRITE = 2'b10,
    OP_READ = 2'b11
  } esq_hop_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_POLL = 3'b001,
    H_CHK = 3'b010,
    H_STEP = 3'b011,
    H_FETCH = 3'b100
  } esq_hstate_t;

endpackage : esq_pkg

// ==== rtl/esq_io_if.sv ====
// I/O register port between the processor core and the EEPROM controller
`timescale 1ns/1ps
`default_nettype none

interface esq_io_if;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic stall;

  modport core (output addr, output wdata, output wr, output rd,
                input rdata, input stall);
  modport dev (input addr, input wdata, input wr, input rd,
               output rdata, output stall);
endinterface : esq_io_if

`default_nettype wire

// ==== rtl/esq_prog_timer.sv ====
// Programming duration timer, advanced by oscillator ticks
`timescale 1ns/1ps
`default_nettype none

module esq_prog_timer #(
  parameter int unsigned TW = 16
) (
  input wire logic pclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [TW-1:0] load,
  input wire logic tick,
  output logic expired
);
  logic [TW-1:0] cnt_ff;
  logic run_ff;

  // Only oscillator ticks move the count, never the core clock alone
  assign expired = run_ff && tick && (cnt_ff == TW'(1));

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end else if (start) begin
      cnt_ff <= load;
      run_ff <= 1'b1;
    end else if (run_ff && tick) begin
      cnt_ff <= cnt_ff - TW'(1);
      run_ff <= !expired;
    end
  end
endmodule : esq_prog_timer

`default_nettype wire

// ==== rtl/esq_device.sv ====
// EEPROM controller: I/O registers, core stall, self-timed programming
`include "esq_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module esq_device
  import esq_pkg::*;
#(
  parameter int unsigned BYTES = `ESQ_BYTES,
  parameter int unsigned ATOMIC_TICKS = `ESQ_ATOMIC_TICKS,
  parameter int unsigned SPLIT_TICKS = `ESQ_SPLIT_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic osc_tick,
  esq_io_if.dev io,
  output logic prog_busy
);
  localparam int AW = $clog2(BYTES);
  localparam int TW = 16;

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  if (!(BYTES == 128 || BYTES == 256 || BYTES == 512)) begin : g_bad_size
    $error("BYTES must be 128, 256 or 512");
  end
  if (ATOMIC_TICKS < 1 || ATOMIC_TICKS > 65535 ||
      SPLIT_TICKS < 1 || SPLIT_TICKS > 65535) begin : g_bad_ticks
    $error("tick counts must be 1 to 65535");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [AW-1:0] addr_ff;
  logic [7:0] data_ff;
  logic [7:0] rdata_ff;
  logic [2:0] arm_cnt_ff;
  logic [2:0] stall_cnt_ff;
  esq_pmode_t mode_ff;
  logic busy_ff;
  esq_pmode_t op_mode_ff;
  logic [AW-1:0] op_addr_ff;
  logic [7:0] op_data_ff;
  logic [7:0] mem_ff [BYTES];

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire wr_ctrl = io.wr && (io.addr == `ESQ_IO_CTRL);
  wire wr_data = io.wr && (io.addr == `ESQ_IO_DATA);
  wire wr_adrl = io.wr && (io.addr == `ESQ_IO_ADRL);
  wire wr_adrh = io.wr && (io.addr == `ESQ_IO_ADRH);
  wire arm_on = (arm_cnt_ff != 3'h0);
  wire [1:0] wr_mode = io.wdata[`ESQ_CTRL_MODE_HI:`ESQ_CTRL_MODE_LO];
  wire prog_expired;

  // Same write may carry a new mode; it already counts when idle
  wire start_prog = wr_ctrl && io.wdata[`ESQ_CTRL_STROBE] && arm_on && !busy_ff
                    && (wr_mode != PM_RSVD);
  wire start_read = wr_ctrl && io.wdata[`ESQ_CTRL_READ] && !busy_ff;
  wire [TW-1:0] prog_load = (wr_mode == PM_ATOMIC) ? TW'(ATOMIC_TICKS)
                                                    : TW'(SPLIT_TICKS);

  // ----------------------------------------------------------------------
  // Address register
  // ----------------------------------------------------------------------
  wire [15:0] addr16 = 16'(addr_ff);
  wire [15:0] adrl_new = {addr16[15:8], io.wdata};
  wire [15:0] adrh_new = {io.wdata, addr16[7:0]};
  wire [AW-1:0] nxt_addr = wr_adrl ? AW'(adrl_new)
                         : wr_adrh ? AW'(adrh_new) : addr_ff;

  // ----------------------------------------------------------------------
  // Read-back mux
  // ----------------------------------------------------------------------
  wire [7:0] ctrl_rd = ({6'h00, mode_ff} << `ESQ_CTRL_MODE_LO)
                     | (8'(arm_on) << `ESQ_CTRL_ARM)
                     | (8'(busy_ff) << `ESQ_CTRL_STROBE);
  wire [7:0] rd_mux = (io.addr == `ESQ_IO_CTRL) ? ctrl_rd
                    : (io.addr == `ESQ_IO_DATA) ? data_ff
                    : (io.addr == `ESQ_IO_ADRL) ? addr16[7:0]
                    : (io.addr == `ESQ_IO_ADRH) ? addr16[15:8]
                    : 8'h00;

  // ----------------------------------------------------------------------
  // Data register
  // ----------------------------------------------------------------------
  wire [7:0] nxt_data = start_read ? mem_ff[addr_ff]
                      : wr_data ? io.wdata : data_ff;

  // ----------------------------------------------------------------------
  // Arm window and stall counters
  // ----------------------------------------------------------------------
  wire [2:0] arm_dec = arm_on ? arm_cnt_ff - 3'h1 : 3'h0;
  wire arm_set = wr_ctrl && io.wdata[`ESQ_CTRL_ARM] && !io.wdata[`ESQ_CTRL_STROBE];
  wire [2:0] nxt_arm = start_prog ? 3'h0
                     : arm_set ? `ESQ_ARM_WINDOW : arm_dec;
  wire [2:0] stall_dec = (stall_cnt_ff != 3'h0) ? stall_cnt_ff - 3'h1 : 3'h0;
  wire [2:0] nxt_stall = start_read ? `ESQ_STALL_READ
                       : start_prog ? `ESQ_STALL_PROG
                       : stall_dec;

  assign io.stall = (stall_cnt_ff != 3'h0);
  assign io.rdata = rdata_ff;
  assign prog_busy = busy_ff;

  // ----------------------------------------------------------------------
  // Core-facing registers, cleared by the system reset
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_ff <= '0;
      data_ff <= 8'h00;
      rdata_ff <= 8'h00;
      arm_cnt_ff <= 3'h0;
      stall_cnt_ff <= 3'h0;
    end else begin
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      rdata_ff <= io.rd ? rd_mux : rdata_ff;
      arm_cnt_ff <= nxt_arm;
      stall_cnt_ff <= nxt_stall;
    end
  end

  // ----------------------------------------------------------------------
  // Mode bits: power-on reset only, system reset acts synchronously
  // ----------------------------------------------------------------------
  // A system reset must not disturb a programming cycle in flight
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      mode_ff <= PM_ATOMIC;
    end else if (!presetn) begin
      mode_ff <= busy_ff ? mode_ff : esq_pmode_t'(`ESQ_MODE_RST);
    end else if (wr_ctrl && !busy_ff) begin
      mode_ff <= esq_pmode_t'(wr_mode);
    end
  end

  // ----------------------------------------------------------------------
  // Programming engine
  // ----------------------------------------------------------------------
  esq_prog_timer #(
    .TW(TW)
  ) u_timer (
    .pclk(pclk),
    .rst_n(por_n),
    .start(start_prog && presetn),
    .load(prog_load),
    .tick(osc_tick),
    .expired(prog_expired)
  );

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      busy_ff <= 1'b0;
      op_mode_ff <= PM_ATOMIC;
      op_addr_ff <= '0;
      op_data_ff <= 8'h00;
    end else if (start_prog && presetn) begin
      busy_ff <= 1'b1;
      op_mode_ff <= esq_pmode_t'(wr_mode);
      op_addr_ff <= addr_ff;
      op_data_ff <= data_ff;
    end else if (prog_expired) begin
      busy_ff <= 1'b0;
    end
  end

  // Erase sets all bits; a plain write can only clear bits
  wire [7:0] old_byte = mem_ff[op_addr_ff];
  logic [7:0] new_byte;
  always_comb begin
    case (op_mode_ff)
      PM_ATOMIC: new_byte = op_data_ff;
      PM_ERASE: new_byte = `ESQ_ERASED;
      PM_WRITE: new_byte = old_byte & op_data_ff;
      default: new_byte = old_byte;
    endcase
  end

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      for (int i = 0; i < BYTES; i++) begin
        mem_ff[i] <= `ESQ_ERASED;
      end
    end else if (prog_expired) begin
      mem_ff[op_addr_ff] <= new_byte;
    end
  end
endmodule : esq_device

`default_nettype wire

// ==== verif/esq_assertions.sv ====
// Concurrent checks on the core-to-controller I/O port
`include "esq_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module esq_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_tick,
  input wire logic prog_busy,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic stall
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [2:0] arm_cnt_ff;
  logic [2:0] nxt_arm_cnt;
  wire logic ctrl_wr;

  assign ctrl_wr = wr && (addr == `ESQ_IO_CTRL);
  // Strobe writes that also carry the arm bit must not re-arm
  assign nxt_arm_cnt = (ctrl_wr && wdata[2] && !wdata[1]) ? 3'h4 :
                       (arm_cnt_ff != 3'h0) ? arm_cnt_ff - 3'h1 : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_cnt_ff <= 3'h0;
    end else begin
      arm_cnt_ff <= nxt_arm_cnt;
    end
  end

  a_read_stall_four: assert property (ctrl_wr && wdata == 8'h01 && !prog_busy
    |=> stall [*4] ##1 !stall) else $error("read stall length wrong");
  a_prog_stall_two: assert property ($rose(prog_busy)
    |-> stall ##1 stall ##1 !stall) else $error("program stall length wrong");
  a_start_needs_arm: assert property ($rose(prog_busy)
    |-> $past(ctrl_wr && wdata[1] && arm_cnt_ff != 3'h0)) else $error("start without arm");
  a_poll_shows_busy: assert property (rd && addr == `ESQ_IO_CTRL
    |=> rdata[1] == $past(prog_busy)) else $error("strobe bit differs from busy");
  a_rdata_holds: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without read");
  a_busy_min_len: assert property ($rose(prog_busy) |-> prog_busy [*8])
    else $error("programming ended too soon");
  a_stall_quiet_core: assert property (stall |-> !wr && !rd)
    else $error("core access during stall");
  a_stall_cause: assert property ($rose(stall)
    |-> $past(ctrl_wr && (wdata[0] || wdata[1]))) else $error("stall without strobe");
  a_busy_end_tick: assert property (!prog_busy && $past(prog_busy) |-> $past(osc_tick))
    else $error("programming ended off oscillator tick");
endmodule : esq_checker

`default_nettype wire

// ==== verif/eeprom_byte_access_sequencer_tb.sv ====
// Self-checking bench: APB host and EEPROM controller joined over the I/O port
`include "esq_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module eeprom_byte_access_sequencer_tb;
  // Short programming counts keep the run small
  localparam int unsigned ATOM_N = 8;
  localparam int unsigned SPLIT_N = 4;

  logic pclk, presetn, por_n, osc_tick, psel, penable, pwrite, pready, pslverr, prog_busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] osc_div_ff;
  int errors, checks, run_ticks, cycles;

  esq_io_if io_link();
  esq_device #(.BYTES(256), .ATOMIC_TICKS(ATOM_N), .SPLIT_TICKS(SPLIT_N)) i_esq_device (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .osc_tick(osc_tick), .io(io_link),
    .prog_busy(prog_busy));
  esq_host #(.AW(9)) i_esq_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io(io_link));
  esq_checker i_esq_checker (.pclk(pclk), .presetn(presetn), .osc_tick(osc_tick),
    .prog_busy(prog_busy), .addr(io_link.addr), .wdata(io_link.wdata), .wr(io_link.wr),
    .rd(io_link.rd), .rdata(io_link.rdata), .stall(io_link.stall));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ----------------------------------------------------------------------
  // Oscillator ticks every 1 us, tick count while busy, hang limit
  // ----------------------------------------------------------------------
  always @(posedge pclk) begin
    if (!por_n) begin
      osc_div_ff <= 4'h0;
      osc_tick <= 1'b0;
    end else begin
      osc_div_ff <= (osc_div_ff == 4'h9) ? 4'h0 : osc_div_ff + 4'h1;
      osc_tick <= (osc_div_ff == 4'h8);
    end
    cycles++;
    if (prog_busy === 1'b1 && osc_tick === 1'b1) run_ticks++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Ends once pready is high; the bench cycle limit catches a pready that never rises
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr32

  task automatic go(input logic [1:0] op, input logic [8:0] a, input logic [7:0] d,
                    output logic [31:0] st);
    logic e;
    wr32(`ESQ_APB_ADDR, {23'h0, a});
    wr32(`ESQ_APB_WDATA, {24'h0, d});
    // A read may overlap a running program, so its count is kept
    if (op != 2'b11) run_ticks = 0;
    wr32(`ESQ_APB_CMD, (32'h1 << `ESQ_CMD_GO) | {30'h0, op});
    do begin
      apb(1'b0, `ESQ_APB_STATUS, 32'h0, st, e);
    end while (st[1:0] !== 2'b10);
  endtask : go

  task automatic prog_end(input int exp);
    while (prog_busy !== 1'b0) begin
      @(posedge pclk);
    end
    chk(run_ticks, exp);
  endtask : prog_end

  task automatic t_regs();
    logic [31:0] q;
    logic e;
    apb(1'b0, `ESQ_APB_STATUS, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
  endtask : t_regs

  task automatic t_split_write();
    logic [31:0] st;
    go(2'b10, 9'h1a5, 8'h3c, st);
    prog_end(SPLIT_N);
    go(2'b11, 9'h1a5, 8'h00, st);
    chk({24'h0, st[15:8]}, 32'h3c);
    go(2'b11, 9'h0a5, 8'h00, st);
    chk({24'h0, st[15:8]}, 32'h3c);
    go(2'b00, 9'h0ff, 8'h81, st);
    prog_end(ATOM_N);
    go(2'b11, 9'h0ff, 8'h00, st);
    chk({24'h0, st[15:8]}, 32'h81);
    go(2'b11, 9'h000, 8'h00, st);
    chk({24'h0, st[15:8]}, 32'hff);
  endtask : t_split_write

  task automatic t_back_to_back();
    logic [31:0] st;
    go(2'b00, 9'h0a5, 8'h5a, st);
    chk({31'h0, prog_busy}, 32'h1);
    go(2'b11, 9'h0a5, 8'h00, st);
    chk({24'h0, st[15:8]}, 32'h5a);
    prog_end(ATOM_N);
  endtask : t_back_to_back

  task automatic t_reset_mid();
    logic [31:0] st;
    go(2'b01, 9'h1a5, 8'h00, st);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({31'h0, prog_busy}, 32'h1);
    prog_end(SPLIT_N);
    go(2'b11, 9'h1a5, 8'h00, st);
    chk({24'h0, st[15:8]}, 32'hff);
  endtask : t_reset_mid

  initial begin
    presetn = 1'b0;
    por_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    t_regs();
    t_split_write();
    t_back_to_back();
    t_reset_mid();
    test_done();
  end
endmodule : eeprom_byte_access_sequencer_tb

`default_nettype wire
